// [common/dcfsf_pkg.sv]
// Shared constants and carriers for the dual-clock FIFO flag block
package dcfsf_pkg;

    // Memory geometry: 2**DEPTH_LOG2 words of DATA_WIDTH bits
    localparam int DEPTH_LOG2 = 12;
    localparam int DATA_WIDTH = 36;

    // Geometry limits the logic can serve
    localparam int DEPTH_LOG2_MIN = 2;
    localparam int DEPTH_LOG2_MAX = 16;

    // Synchroniser depth between the two port-clock regions
    localparam int SYNC_STAGES = 2;

    // Flag values held during and just after reset
    localparam logic RST_EMPTY_OR_READY = 1'b0;
    localparam logic RST_ALMOST_EMPTY   = 1'b0;
    localparam logic RST_ALMOST_FULL    = 1'b1;
    localparam logic RST_FULL_OR_READY  = 1'b1;

    // Timing modes of the empty/output-ready flag
    typedef enum logic [0:0] {
        MODE_STANDARD     = 1'b0,
        MODE_FALL_THROUGH = 1'b1
    } dcfsf_mode_type;

    // Port controls sampled on a port-clock rising edge
    typedef struct packed {
        logic select_n;
        logic direction;
        logic enable;
        logic mailbox_select;
    } dcfsf_port_ctl_type;

endpackage

// [src/dcfsf_fifo.sv]
`timescale 1ns/1ps

module dcfsf_fifo #(
    parameter int AW = dcfsf_pkg::DEPTH_LOG2,
    parameter int DW = dcfsf_pkg::DATA_WIDTH
) (
    // System clock and reset
    input  wire logic                           i_mclk,
    input  wire logic                           i_rstn,
    // Configuration held static from reset
    input  wire logic                           i_fall_through_mode,
    input  wire logic [AW:0]                    i_ae_offset,
    input  wire logic [AW:0]                    i_af_offset,
    // Write port
    input  wire logic                           i_write_port_clock,
    input  wire dcfsf_pkg::dcfsf_port_ctl_type  i_write_ctl,
    input  wire logic [DW-1:0]                  i_write_data,
    // Read port
    input  wire logic                           i_read_port_clock,
    input  wire dcfsf_pkg::dcfsf_port_ctl_type  i_read_ctl,
    output logic      [DW-1:0]                  o_read_data,
    // Status flags
    output logic                                o_empty_or_output_ready_flag,
    output logic                                o_almost_empty_flag,
    output logic                                o_almost_full_flag,
    output logic                                o_full_or_input_ready_flag
);

    // Refuse geometries the pointer logic cannot serve
    generate
        // Pointer arithmetic needs a few words of depth
        if (AW < dcfsf_pkg::DEPTH_LOG2_MIN) begin : g_aw_small
            $error("dcfsf_fifo: address width below supported range");
        end
        // Very deep memories are not supported
        if (AW > dcfsf_pkg::DEPTH_LOG2_MAX) begin : g_aw_large
            $error("dcfsf_fifo: address width above supported range");
        end
        if (DW < 1) begin : g_dw_bad
            $error("dcfsf_fifo: data width must be at least one bit");
        end
        // The crossing below is built as exactly two stages
        if (dcfsf_pkg::SYNC_STAGES != 2) begin : g_sync_bad
            $error("dcfsf_fifo: only a two-stage synchroniser is built");
        end
    endgenerate

    // Capacity and unit step at pointer width, wrap bit included
    localparam logic [AW:0] DEPTH_W   = (AW+1)'(1) << AW;
    localparam logic [AW:0] ONE_W     = (AW+1)'(1);
    localparam int          MEM_WORDS = 2**AW;

    // Entire state of the block apart from the data memory
    typedef struct packed {
        // Port clock levels at the last system edge
        logic          wclk_prev;
        logic          rclk_prev;
        // Own pointers, binary and Gray
        logic [AW:0]   wptr;
        logic [AW:0]   rptr;
        logic [AW:0]   wgray;
        logic [AW:0]   rgray;
        // Far-side pointers, two stages each
        logic [AW:0]   wsync1;
        logic [AW:0]   wsync2;
        logic [AW:0]   rsync1;
        logic [AW:0]   rsync2;
        // Output register and its valid bit
        logic [DW-1:0] dout;
        logic          out_ready;
        // Registered flags
        logic          ef;
        logic          ae;
        logic          af;
        logic          ff;
    } dcfsf_state_type;

    dcfsf_state_type s_q;
    dcfsf_state_type s_d;

    // Data memory, one word per location
    logic [DW-1:0] mem [MEM_WORDS];
    // Accepted write in this cycle and the selected timing mode
    logic          wr_go;
    logic          fall_through_mode;
    // Words in memory as seen from each side
    logic [AW:0]   rd_count;
    logic [AW:0]   wr_count;
    // Port decodes and pointer steps
    logic          wr_sel;
    logic          rd_sel;
    logic [AW:0]   wptr_inc;
    logic [AW:0]   rptr_inc;
    // Far-side pointers in binary
    logic [AW:0]   wptr_seen;
    logic [AW:0]   rptr_seen;
    // Memory addresses and the word at the head
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] head_word;

    // Binary to Gray conversion
    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary conversion, used on both sides
    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Port decode of a FIFO transfer (not mailbox)
    function automatic logic port_selected(input dcfsf_pkg::dcfsf_port_ctl_type c);
        return ~c.select_n & c.direction & c.enable & ~c.mailbox_select;
    endfunction

    // Almost-empty level: more than X words held in memory
    function automatic logic above_offset(input logic [AW:0] count,
                                          input logic [AW:0] offset);
        return (count > offset);
    endfunction

    // Almost-full level: high while the count is below capacity less Y
    function automatic logic below_ceiling(input logic [AW:0] count,
                                           input logic [AW:0] offset);
        return (count < (DEPTH_W - offset));
    endfunction

    // Space level: high while at least one location is free
    function automatic logic has_space(input logic [AW:0] count);
        return (count != DEPTH_W);
    endfunction

    // FIFO transfer decodes of both ports, mailbox traffic excluded
    assign wr_sel = port_selected(i_write_ctl);
    assign rd_sel = port_selected(i_read_ctl);

    // Pointer steps shared by the binary and Gray copies
    assign wptr_inc = s_q.wptr + ONE_W;
    assign rptr_inc = s_q.rptr + ONE_W;

    // Far-side pointers after the second synchroniser stage, in binary
    assign wptr_seen = gray2bin(s_q.wsync2);
    assign rptr_seen = gray2bin(s_q.rsync2);

    // Memory addresses drop the wrap bit
    assign wr_addr   = s_q.wptr[AW-1:0];
    assign rd_addr   = s_q.rptr[AW-1:0];
    assign head_word = mem[rd_addr];

    // Next-state logic for both port regions
    always_comb begin
        // Local decode of this cycle
        logic wedge;
        logic redge;
        logic avail;
        logic load;
        wedge = 1'b0;
        redge = 1'b0;
        avail = 1'b0;
        load  = 1'b0;
        // Hold pointers, synchronisers and output unless a port edge moves them
        s_d   = s_q;
        // Mode pin is static from reset
        fall_through_mode  = (dcfsf_pkg::dcfsf_mode_type'(i_fall_through_mode) ==
                 dcfsf_pkg::MODE_FALL_THROUGH);

        // Port clocks are sampled; rising edges become enables
        wedge = i_write_port_clock & ~s_q.wclk_prev;
        redge = i_read_port_clock & ~s_q.rclk_prev;
        s_d.wclk_prev = i_write_port_clock;
        s_d.rclk_prev = i_read_port_clock;

        // Memory words seen by each side (output register excluded)
        // Wrap bit keeps full and empty apart
        rd_count = wptr_seen - s_q.rptr;
        wr_count = s_q.wptr - rptr_seen;
        avail    = (rd_count != '0);

        // Write side: accept only with space available
        wr_go = wedge & wr_sel & s_q.ff;
        if (wr_go) begin
            s_d.wptr  = wptr_inc;
            // Gray copy is what crosses to the read side
            s_d.wgray = bin2gray(wptr_inc);
        end

        // Read pointer crosses into the write side
        if (wedge) begin
            // Only the second stage reads the first
            s_d.rsync1 = s_q.rgray;
            s_d.rsync2 = s_q.rsync1;
        end

        // Write pointer crosses into the read side
        if (redge) begin
            // Only the second stage reads the first
            s_d.wsync1 = s_q.wgray;
            s_d.wsync2 = s_q.wsync1;
        end

        // Output register loading per timing mode
        if (redge) begin
            if (fall_through_mode) begin
                // Empty output register fills itself from memory
                if (!s_q.out_ready) begin
                    load = avail;
                end else if (rd_sel) begin
                    load = avail;
                    if (!avail) begin
                        s_d.out_ready = 1'b0;
                    end
                end
            end else begin
                // Standard mode loads only on a selected read with data waiting
                load = rd_sel & s_q.ef;
            end
        end
        if (load) begin
            s_d.dout      = head_word;
            s_d.rptr      = rptr_inc;
            // Gray copy is what crosses to the write side
            s_d.rgray     = bin2gray(rptr_inc);
            s_d.out_ready = 1'b1;
        end

        // Read-side flags settle from the second synchroniser stage
        s_d.ef = fall_through_mode ? s_d.out_ready : avail;
        s_d.ae = above_offset(rd_count, i_ae_offset);
        // Write-side flags settle from the second synchroniser stage
        s_d.af = below_ceiling(wr_count, i_af_offset);
        s_d.ff = has_space(wr_count);
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            // Pointers, synchronisers and data clear
            s_q.wclk_prev <= 1'b0;
            s_q.rclk_prev <= 1'b0;
            s_q.wptr      <= '0;
            s_q.rptr      <= '0;
            s_q.wgray     <= '0;
            s_q.rgray     <= '0;
            s_q.wsync1    <= '0;
            s_q.wsync2    <= '0;
            s_q.rsync1    <= '0;
            s_q.rsync2    <= '0;
            s_q.dout      <= '0;
            s_q.out_ready <= 1'b0;
            // Flags take their idle levels
            s_q.ef        <= dcfsf_pkg::RST_EMPTY_OR_READY;
            s_q.ae        <= dcfsf_pkg::RST_ALMOST_EMPTY;
            s_q.af        <= dcfsf_pkg::RST_ALMOST_FULL;
            s_q.ff        <= dcfsf_pkg::RST_FULL_OR_READY;
        end else begin
            s_q <= s_d;
        end
    end

    // Data memory, written on accepted writes
    always_ff @(posedge i_mclk) begin
        if (wr_go) begin
            mem[wr_addr] <= i_write_data;
        end
    end

    // Output register drives the read data
    assign o_read_data                  = s_q.dout;
    // Read-side flags straight from the state register
    assign o_empty_or_output_ready_flag = s_q.ef;
    assign o_almost_empty_flag          = s_q.ae;
    // Write-side flags straight from the state register
    assign o_almost_full_flag           = s_q.af;
    assign o_full_or_input_ready_flag   = s_q.ff;

endmodule

// [verif/dcfsf_fifo_monitor.sv]
`timescale 1ns/1ps
module dcfsf_fifo_monitor (
    // Watched design ports
    input wire logic        i_mclk, i_rstn, i_fall_through_mode,
    input wire logic        i_write_port_clock, i_read_port_clock,
    input wire logic [35:0] o_read_data,
    input wire logic        o_empty_or_output_ready_flag, o_almost_empty_flag,
    input wire logic        o_almost_full_flag, o_full_or_input_ready_flag
);
    // Port clock levels at the last three edges, short flag names
    logic [2:0] wh_q, rh_q;
    wire ef = o_empty_or_output_ready_flag, ae = o_almost_empty_flag;
    wire ff = o_full_or_input_ready_flag, af = o_almost_full_flag;
    always_ff @(posedge i_mclk) begin
        wh_q <= {wh_q[1:0], i_write_port_clock};
        rh_q <= {rh_q[1:0], i_read_port_clock};
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    property p_rst; $rose(i_rstn) |-> {ef, ae, af, ff} == 4'h3; endproperty
    a_rst: assert property (p_rst) else $error("flags not idle");
    property p_full; !ff |-> !af; endproperty
    a_full: assert property (p_full) else $error("full, af high");
    property p_efr; $rose(ef) |-> |rh_q; endproperty
    a_efr: assert property (p_efr) else $error("ef rose off edge");
    property p_ffr; $rose(ff) |-> |wh_q; endproperty
    a_ffr: assert property (p_ffr) else $error("ff rose off edge");
    property p_fff; $fell(ff) |-> |wh_q; endproperty
    a_fff: assert property (p_fff) else $error("ff fell off edge");
    property p_load; $changed(o_read_data) |-> |rh_q; endproperty
    a_load: assert property (p_load) else $error("load off edge");
    property p_sread; !i_fall_through_mode && $changed(o_read_data) |-> ef || $past(ef); endproperty
    a_sread: assert property (p_sread) else $error("read while empty");
    property p_ftld; i_fall_through_mode && $rose(ef) |-> $changed(o_read_data); endproperty
    a_ftld: assert property (p_ftld) else $error("no word with ready");
    // Main scenarios reached
    c_ft: cover property (i_fall_through_mode && $rose(ef));
    c_full: cover property ($fell(ff));
    c_ae: cover property ($rose(ae));
endmodule
bind dcfsf_fifo dcfsf_fifo_monitor mon_u (.*);

// [verif/dcfsf_port_model.sv]
`timescale 1ns/1ps
module dcfsf_port_model (
    // System clock and flags in, port pins out
    input  wire logic                     i_mclk, i_ff, i_ef,
    output logic                          o_wclk, o_rclk,
    output dcfsf_pkg::dcfsf_port_ctl_type o_wctl, o_rctl
);
    // Idle: clocks low, ports deselected
    initial begin
        {o_wclk, o_rclk} = 2'h0;
        {o_wctl, o_rctl} = 8'h88;
    end
    // One port cycle: low 3, high 2, low 2 system cycles
    task automatic cyc(input bit w, r, output bit wa, ra);
        @(posedge i_mclk) #1;
        o_wctl = {1'b0, 1'b1, w, 1'b0};
        o_rctl = {1'b0, 1'b1, r, 1'b0};
        repeat (2) @(posedge i_mclk);
        #1 {wa, ra} = {w & i_ff, r & i_ef};
        {o_wclk, o_rclk} = 2'h3;
        repeat (2) @(posedge i_mclk);
        #1 {o_wclk, o_rclk} = 2'h0;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
endmodule

// [verif/dcfsf_fifo_tb_top.sv]
`timescale 1ns/1ps
module dcfsf_fifo_tb_top;
    // Bench signals and reference queue
    logic                          i_mclk, i_rstn, mode, wclk, rclk, ef, ae, af, ff;
    dcfsf_pkg::dcfsf_port_ctl_type wctl, rctl;
    logic [35:0]                   wdata, rdata, q[$];
    int                            num_errors, comparisons, seed, n;
    bit                            wa, ra;
    always #2.5 i_mclk = ~i_mclk; // 5 ns system clock
    dcfsf_fifo #(.AW(3)) dut_u (.i_mclk, .i_rstn, .i_fall_through_mode(mode),
        .i_ae_offset(4'h2), .i_af_offset(4'h2), .i_write_port_clock(wclk),
        .i_write_ctl(wctl), .i_write_data(wdata), .i_read_port_clock(rclk),
        .i_read_ctl(rctl), .o_read_data(rdata), .o_empty_or_output_ready_flag(ef),
        .o_almost_empty_flag(ae), .o_almost_full_flag(af), .o_full_or_input_ready_flag(ff));
    dcfsf_port_model pm_u (.i_mclk, .i_ff(ff), .i_ef(ef), .o_wclk(wclk), .o_rclk(rclk),
        .o_wctl(wctl), .o_rctl(rctl));
    // Count a comparison and report a mismatch
    task automatic chk(input logic [35:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic close_out;
        $display("Counts: %0d errors, %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One port cycle with reference update; released data lines toggle
    task automatic op(input bit w, r);
        logic [35:0] d;
        d = 36'($random(seed));
        wdata = w ? d : ~wdata;
        pm_u.cyc(w, r, wa, ra);
        if (wa) q.push_back(d);
        if (ra) d = q.pop_front();
        if (ra && !mode) chk(rdata, d, "read data");
        if (mode && ef === 1'b1 && q.size() > 0) chk(rdata, q[0], "head");
    endtask
    // Idle port cycles until a flag is high
    task automatic settle(input bit f, input int exp);
        n = 0;
        do begin
            op(1'b0, 1'b0);
            n++;
        end while ((f ? ff : ef) !== 1'b1 && n < 9);
        chk(36'(n), 36'(exp), "sync cycles");
    endtask
    // Both modes: latency, fill, drain, then random traffic
    initial begin
        {i_mclk, i_rstn, wdata} = '0;
        {seed, num_errors, comparisons} = {32'd18, 64'd0};
        for (int m = 0; m < 2; m++) begin
            {i_rstn, mode} = {1'b0, m[0]};
            q.delete();
            repeat (16) @(posedge i_mclk);
            #1 i_rstn = 1'b1;
            chk(36'({ef, ae, af, ff}), 36'h3, "reset flags");
            op(1'b1, 1'b0);
            settle(1'b0, 2 + m);
            repeat (12) op(1'b1, 1'b0);
            repeat (4) op(1'b0, 1'b0);
            chk(36'(q.size()), 36'(8 + m), "fill");
            chk(36'({ef, ae, af, ff}), 36'hC, "full flags");
            op(1'b0, 1'b1);
            settle(1'b1, 2);
            while (ef === 1'b1 && q.size() > 0) op(1'b0, 1'b1);
            repeat (4) op(1'b0, 1'b0);
            chk(36'({ef, ae, af, ff, q.size() != 0}), 36'h6, "empty");
            repeat (150) op(1'($random(seed)), 1'($random(seed)));
            $display("Test in mode %0d done", m);
        end
        close_out();
    end
    // Watchdog: over four times the expected 2600 system cycles
    initial begin
        #60000;
        num_errors++;
        close_out();
    end
endmodule
